// ===== hw/vidwin_pkg.sv
// vidwin_pkg: constants for the video active-area and sub-image window block
// Overview of operation
// - count lines, one per hsync, from the vsync edge chosen by field select.
// - count pixels in video clocks from hsync leading edge, either bus width.
// - flag as processed only pixels inside the active-area rectangle.
// - sync master/slave setting has no effect on any window decision.
// - active vertical start N makes line N+1 the first processed line.
// - active vertical end N makes line N the last processed line.
// - active horizontal start N makes pixel N+1 the first processed pixel.
// - active horizontal end N makes pixel N the last processed pixel.
// - sub-image vertical start N makes line N+1 the first window line.
// - sub-image vertical end N makes line N the last window line.
// - sub-image horizontal start N makes pixel N+1 the first window pixel.
// - sub-image horizontal end N makes pixel N the last window pixel.
// - field starts at vsync leading edge when select is 0, trailing when 1.
// - indicator output shows polarity level outside the sub-image, opposite inside; its status bit is 1 inside at either polarity.
package vidwin_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int LINE_W = 16;
   localparam int PIX_W = 10;
   localparam int HIGH_PIX_BITS = 2;
   // register offsets
   localparam logic [7:0] VIDEO_CONTROL_OFS = 8'h30;
   localparam logic [7:0] VIDEO_POLARITY_OFS = 8'h31;
   localparam logic [7:0] ACTIVE_VERT_START_HIGH_OFS = 8'h42;
   localparam logic [7:0] ACTIVE_VERT_START_LOW_OFS = 8'h43;
   localparam logic [7:0] ACTIVE_VERT_END_HIGH_OFS = 8'h44;
   localparam logic [7:0] ACTIVE_VERT_END_LOW_OFS = 8'h45;
   localparam logic [7:0] ACTIVE_HORIZ_START_HIGH_OFS = 8'h46;
   localparam logic [7:0] ACTIVE_HORIZ_START_LOW_OFS = 8'h47;
   localparam logic [7:0] ACTIVE_HORIZ_END_HIGH_OFS = 8'h48;
   localparam logic [7:0] ACTIVE_HORIZ_END_LOW_OFS = 8'h49;
   localparam logic [7:0] WINDOW_VERT_START_HIGH_OFS = 8'h4A;
   localparam logic [7:0] WINDOW_VERT_START_LOW_OFS = 8'h4B;
   localparam logic [7:0] WINDOW_VERT_END_HIGH_OFS = 8'h4C;
   localparam logic [7:0] WINDOW_VERT_END_LOW_OFS = 8'h4D;
   localparam logic [7:0] WINDOW_HORIZ_START_HIGH_OFS = 8'h4E;
   localparam logic [7:0] WINDOW_HORIZ_START_LOW_OFS = 8'h4F;
   localparam logic [7:0] WINDOW_HORIZ_END_HIGH_OFS = 8'h50;
   localparam logic [7:0] WINDOW_HORIZ_END_LOW_OFS = 8'h51;
   localparam logic [7:0] WINDOW_STATUS_OFS = 8'h52;
   localparam int WIN_REG_COUNT = 16;
   // field positions
   localparam int SYNC_MASTER_BIT = 0;
   localparam int FIELD_EDGE_BIT = 2;
   localparam int VSYNC_POL_BIT = 0;
   localparam int HSYNC_POL_BIT = 1;
   localparam int SUBIMAGE_INDICATOR_POL_BIT = 4;
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_SUBIMAGE_INDICATOR_BIT = 1;
   localparam int STAT_VSYNC_BIT = 2;
   localparam int STAT_HSYNC_BIT = 3;
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] POLARITY_RESET = 8'h00;
   localparam logic [7:0] WINDOW_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [7:0] CONTROL_MASK = 8'h0F;
endpackage : vidwin_pkg

// ===== hw/vidwin_pin_sync.sv
// vidwin_pin_sync: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module vidwin_pin_sync #(
   parameter int WIDTH = 1
) (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   // pins and filtered levels
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;

   always_comb begin
      lvl_next = lvl_reg;
      for (int i = 0; i < WIDTH; i++) begin
         // stage one is never looked at here, only stages two and three
         if (s2_reg[i] == s3_reg[i]) begin
            lvl_next[i] = s3_reg[i];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         lvl_reg <= '0;
      end else if (clk_en_in) begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= lvl_next;
      end
   end

   assign level_out = lvl_reg;
endmodule : vidwin_pin_sync
`default_nettype wire

// ===== hw/vidwin_rect.sv
// vidwin_rect: inside test of a line/pixel pair against one rectangle
`timescale 1ns/1ps
`default_nettype none
module vidwin_rect #(
   parameter int LW = 16,
   parameter int PW = 10
) (
   // counters
   input wire logic [LW-1:0] line_in,
   input wire logic [PW-1:0] pix_in,
   // limits
   input wire logic [LW-1:0] first_line_in,
   input wire logic [LW-1:0] last_line_in,
   input wire logic [PW-1:0] first_pix_in,
   input wire logic [PW-1:0] last_pix_in,
   // result
   output logic inside_out
);
   logic v_ok, h_ok;
   // start N means N+1 is first; end N means N is last
   assign v_ok = (line_in > first_line_in) && (line_in <= last_line_in);
   assign h_ok = (pix_in > first_pix_in) && (pix_in <= last_pix_in);
   assign inside_out = v_ok && h_ok;
endmodule : vidwin_rect
`default_nettype wire

// ===== hw/vidwin_top.sv
// vidwin_top: active-area and sub-image window timing for the pixel port
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module vidwin_top
   import vidwin_pkg::*;
(
   // core clock, reset, enable
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   input wire logic CLK_EN_IN,
   // register port
   input wire logic [ADDR_W-1:0] REG_ADDR_IN,
   input wire logic [DATA_W-1:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [DATA_W-1:0] REG_RDATA_OUT,
   // video link pins
   input wire logic VIDEO_PIXEL_CLOCK_IN,
   input wire logic HSYNC_IN,
   input wire logic VSYNC_IN,
   // window outputs
   output logic ACTIVE_PIXEL_OUT,
   output logic SUBIMAGE_INDICATOR_OUT,
   output logic PIXEL_STROBE_OUT
);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [2:0] pins_lvl;
   logic video_pixel_clock_lvl, hs_lvl, vs_lvl;

   vidwin_pin_sync #(
      .WIDTH(3)
   ) u_pins (
      .clk_in(CORE_CLK_IN),
      .rst_in(RST_IN),
      .clk_en_in(CLK_EN_IN),
      .pin_in({VSYNC_IN, HSYNC_IN, VIDEO_PIXEL_CLOCK_IN}),
      .level_out(pins_lvl)
   );

   assign video_pixel_clock_lvl = pins_lvl[0];
   assign hs_lvl = pins_lvl[1];
   assign vs_lvl = pins_lvl[2];

   ////////////////////////////////////////////////////////////////////////
   // register file

   logic [DATA_W-1:0] win_reg [WIN_REG_COUNT];
   logic [DATA_W-1:0] win_next [WIN_REG_COUNT];
   logic [DATA_W-1:0] control_reg, control_next;
   logic [DATA_W-1:0] polarity_reg, polarity_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [DATA_W-1:0] status_byte;
   logic win_hit;
   logic [ADDR_W-1:0] win_idx_full;
   logic [3:0] win_idx;

   assign win_idx_full = REG_ADDR_IN - ACTIVE_VERT_START_HIGH_OFS;
   assign win_idx = win_idx_full[3:0];
   assign win_hit = (REG_ADDR_IN >= ACTIVE_VERT_START_HIGH_OFS) &&
                    (REG_ADDR_IN <= WINDOW_HORIZ_END_LOW_OFS);

   always_comb begin
      control_next = control_reg;
      polarity_next = polarity_reg;
      for (int i = 0; i < WIN_REG_COUNT; i++) begin
         win_next[i] = win_reg[i];
      end
      if (REG_WR_IN) begin
         if (REG_ADDR_IN == VIDEO_CONTROL_OFS) begin
            control_next = REG_WDATA_IN & CONTROL_MASK;
         end else if (REG_ADDR_IN == VIDEO_POLARITY_OFS) begin
            polarity_next = REG_WDATA_IN;
         end else if (win_hit) begin
            win_next[win_idx] = REG_WDATA_IN;
         end
      end
   end

   always_comb begin
      rdata_next = UNMAPPED_READ;
      if (REG_RD_IN) begin
         if (REG_ADDR_IN == VIDEO_CONTROL_OFS) begin
            rdata_next = control_reg;
         end else if (REG_ADDR_IN == VIDEO_POLARITY_OFS) begin
            rdata_next = polarity_reg;
         end else if (win_hit) begin
            rdata_next = win_reg[win_idx];
         end else if (REG_ADDR_IN == WINDOW_STATUS_OFS) begin
            rdata_next = status_byte;
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         control_reg <= CONTROL_RESET;
         polarity_reg <= POLARITY_RESET;
         rdata_reg <= UNMAPPED_READ;
         for (int i = 0; i < WIN_REG_COUNT; i++) begin
            win_reg[i] <= WINDOW_RESET;
         end
      end else if (CLK_EN_IN) begin
         control_reg <= control_next;
         polarity_reg <= polarity_next;
         rdata_reg <= rdata_next;
         for (int i = 0; i < WIN_REG_COUNT; i++) begin
            win_reg[i] <= win_next[i];
         end
      end
   end

   assign REG_RDATA_OUT = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // window limits, joined from byte pairs

   localparam int IVSH = 0;
   localparam int IVEH = 2;
   localparam int IHSH = 4;
   localparam int IHEH = 6;
   localparam int SUB = 8;

   logic [LINE_W-1:0] act_first_line, act_last_line;
   logic [LINE_W-1:0] sub_first_line, sub_last_line;
   logic [PIX_W-1:0] act_first_pix, act_last_pix;
   logic [PIX_W-1:0] sub_first_pix, sub_last_pix;

   // horizontal high bytes keep only their two low bits
   assign act_first_line = {win_reg[IVSH], win_reg[IVSH+1]};
   assign act_last_line = {win_reg[IVEH], win_reg[IVEH+1]};
   assign act_first_pix = {win_reg[IHSH][HIGH_PIX_BITS-1:0],
                           win_reg[IHSH+1]};
   assign act_last_pix = {win_reg[IHEH][HIGH_PIX_BITS-1:0],
                          win_reg[IHEH+1]};
   assign sub_first_line = {win_reg[SUB+IVSH], win_reg[SUB+IVSH+1]};
   assign sub_last_line = {win_reg[SUB+IVEH], win_reg[SUB+IVEH+1]};
   assign sub_first_pix = {win_reg[SUB+IHSH][HIGH_PIX_BITS-1:0],
                           win_reg[SUB+IHSH+1]};
   assign sub_last_pix = {win_reg[SUB+IHEH][HIGH_PIX_BITS-1:0],
                          win_reg[SUB+IHEH+1]};

   ////////////////////////////////////////////////////////////////////////
   // line and pixel counters on the sampled video clock

   logic field_edge_sel, subimage_indicator_pol, hs_pol, vs_pol;
   logic video_pixel_clock_prev_reg, video_pixel_clock_prev_next;
   logic hs_prev_reg, hs_prev_next;
   logic vs_prev_reg, vs_prev_next;
   logic [LINE_W-1:0] line_reg, line_next;
   logic [PIX_W-1:0] pix_reg, pix_next;
   logic video_pixel_clock_rise, hs_act, vs_act, hs_lead, vs_lead, vs_trail, field_start;

   // the master/slave bit is stored for software only, never read here
   assign field_edge_sel = control_reg[FIELD_EDGE_BIT];
   assign subimage_indicator_pol = polarity_reg[SUBIMAGE_INDICATOR_POL_BIT];
   assign hs_pol = polarity_reg[HSYNC_POL_BIT];
   assign vs_pol = polarity_reg[VSYNC_POL_BIT];

   // one pixel per video clock, regardless of bus width
   assign video_pixel_clock_rise = video_pixel_clock_lvl && !video_pixel_clock_prev_reg;
   assign hs_act = (hs_lvl == hs_pol);
   assign vs_act = (vs_lvl == vs_pol);
   assign hs_lead = hs_act && !hs_prev_reg;
   assign vs_lead = vs_act && !vs_prev_reg;
   assign vs_trail = !vs_act && vs_prev_reg;
   assign field_start = field_edge_sel ? vs_trail : vs_lead;

   always_comb begin
      video_pixel_clock_prev_next = video_pixel_clock_lvl;
      hs_prev_next = hs_prev_reg;
      vs_prev_next = vs_prev_reg;
      line_next = line_reg;
      pix_next = pix_reg;
      if (video_pixel_clock_rise) begin
         hs_prev_next = hs_act;
         vs_prev_next = vs_act;
         if (hs_lead) begin
            pix_next = '0;
         end else if (pix_reg != {PIX_W{1'b1}}) begin
            // saturates so that a missing hsync cannot wrap into a window
            pix_next = pix_reg + 1'b1;
         end
         if (field_start) begin
            line_next = '0;
         end else if (hs_lead && (line_reg != {LINE_W{1'b1}})) begin
            line_next = line_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         video_pixel_clock_prev_reg <= 1'b0;
         hs_prev_reg <= 1'b0;
         vs_prev_reg <= 1'b0;
         line_reg <= '0;
         pix_reg <= '0;
      end else if (CLK_EN_IN) begin
         video_pixel_clock_prev_reg <= video_pixel_clock_prev_next;
         hs_prev_reg <= hs_prev_next;
         vs_prev_reg <= vs_prev_next;
         line_reg <= line_next;
         pix_reg <= pix_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // window comparison and outputs

   logic act_inside, sub_inside;
   logic active_reg, active_next;
   logic subind_reg, subind_next;
   logic strobe_reg, strobe_next;
   logic sub_state_reg, sub_state_next;

   // start N: first is N+1, end N: last is N
   vidwin_rect #(
      .LW(LINE_W),
      .PW(PIX_W)
   ) u_active (
      .line_in(line_reg),
      .pix_in(pix_reg),
      .first_line_in(act_first_line),
      .last_line_in(act_last_line),
      .first_pix_in(act_first_pix),
      .last_pix_in(act_last_pix),
      .inside_out(act_inside)
   );

   // same limits scheme for the sub-image
   vidwin_rect #(
      .LW(LINE_W),
      .PW(PIX_W)
   ) u_subimage (
      .line_in(line_reg),
      .pix_in(pix_reg),
      .first_line_in(sub_first_line),
      .last_line_in(sub_last_line),
      .first_pix_in(sub_first_pix),
      .last_pix_in(sub_last_pix),
      .inside_out(sub_inside)
   );

   // decisions follow the counters one core cycle after each pixel edge
   always_comb begin
      active_next = act_inside;
      sub_state_next = sub_inside;
      subind_next = sub_inside ^ subimage_indicator_pol;
      strobe_next = video_pixel_clock_rise;
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         active_reg <= 1'b0;
         sub_state_reg <= 1'b0;
         subind_reg <= 1'b0;
         strobe_reg <= 1'b0;
      end else if (CLK_EN_IN) begin
         active_reg <= active_next;
         sub_state_reg <= sub_state_next;
         subind_reg <= subind_next;
         strobe_reg <= strobe_next;
      end
   end

   assign ACTIVE_PIXEL_OUT = active_reg;
   assign SUBIMAGE_INDICATOR_OUT = subind_reg;
   assign PIXEL_STROBE_OUT = strobe_reg;

   always_comb begin
      status_byte = 8'h00;
      status_byte[STAT_ACTIVE_BIT] = active_reg;
      status_byte[STAT_SUBIMAGE_INDICATOR_BIT] = sub_state_reg;
      status_byte[STAT_VSYNC_BIT] = vs_act;
      status_byte[STAT_HSYNC_BIT] = hs_act;
   end

endmodule : vidwin_top
`default_nettype wire

// ===== test/vidwin_chk_sva.sv
// vidwin_chk_sva: port-level assertions for the window timing block
`timescale 1ns/1ps
`default_nettype none
module vidwin_chk
   import vidwin_pkg::*;
(
   // core clock, reset, enable
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   input wire logic CLK_EN_IN,
   // register port
   input wire logic [ADDR_W-1:0] REG_ADDR_IN,
   input wire logic [DATA_W-1:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [DATA_W-1:0] REG_RDATA_OUT,
   // video link pins
   input wire logic VIDEO_PIXEL_CLOCK_IN,
   input wire logic HSYNC_IN,
   input wire logic VSYNC_IN,
   // window outputs
   input wire logic ACTIVE_PIXEL_OUT,
   input wire logic SUBIMAGE_INDICATOR_OUT,
   input wire logic PIXEL_STROBE_OUT
);
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);
   ////////////////////////////////////////////////////////////////////////////
   rd_idle_zero_a: assert property (CLK_EN_IN && !REG_RD_IN |=>
      REG_RDATA_OUT == 8'h00) else $error("read data not idle zero");
   unmapped_rd_a: assert property (REG_RD_IN && REG_ADDR_IN > 8'h52 |=>
      REG_RDATA_OUT == UNMAPPED_READ) else $error("unmapped read not zero");
   act_readback_a: assert property (REG_WR_IN && REG_ADDR_IN >= 8'h42 &&
      REG_ADDR_IN <= 8'h45 ##1 REG_RD_IN && $stable(REG_ADDR_IN)
      |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2)) else $error("active readback");
   sub_readback_a: assert property (REG_WR_IN && REG_ADDR_IN >= 8'h4A &&
      REG_ADDR_IN <= 8'h4D ##1 REG_RD_IN && $stable(REG_ADDR_IN)
      |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2)) else $error("window readback");
   strobe_single_a: assert property (PIXEL_STROBE_OUT |=>
      !PIXEL_STROBE_OUT) else $error("strobe longer than one cycle");
   strobe_follow_a: assert property ($rose(VIDEO_PIXEL_CLOCK_IN) |->
      ##[3:8] PIXEL_STROBE_OUT) else $error("pixel step missed");
   still_clock_a: assert property (!VIDEO_PIXEL_CLOCK_IN [*8] |->
      !PIXEL_STROBE_OUT) else $error("pixel step without clock");
   act_hold_a: assert property (!PIXEL_STROBE_OUT && !REG_WR_IN &&
      !$past(REG_WR_IN) |=> $stable(ACTIVE_PIXEL_OUT))
      else $error("active flag moved between steps");
   sub_hold_a: assert property (!PIXEL_STROBE_OUT && !REG_WR_IN &&
      !$past(REG_WR_IN) |=> $stable(SUBIMAGE_INDICATOR_OUT))
      else $error("indicator moved between steps");
   // main scenarios reached
   cover property (PIXEL_STROBE_OUT ##1 ACTIVE_PIXEL_OUT);
   cover property ($rose(SUBIMAGE_INDICATOR_OUT));
   cover property ($fell(SUBIMAGE_INDICATOR_OUT));
   cover property (REG_RD_IN ##1 REG_RDATA_OUT != 8'h00);
endmodule : vidwin_chk
bind vidwin_top vidwin_chk u_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
   .CLK_EN_IN(CLK_EN_IN), .REG_ADDR_IN(REG_ADDR_IN),
   .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
   .REG_RDATA_OUT(REG_RDATA_OUT), .VIDEO_PIXEL_CLOCK_IN(VIDEO_PIXEL_CLOCK_IN),
   .HSYNC_IN(HSYNC_IN), .VSYNC_IN(VSYNC_IN), .ACTIVE_PIXEL_OUT(ACTIVE_PIXEL_OUT),
   .SUBIMAGE_INDICATOR_OUT(SUBIMAGE_INDICATOR_OUT),
   .PIXEL_STROBE_OUT(PIXEL_STROBE_OUT));
`default_nettype wire

// ===== test/vidwin_video_src.sv
// vidwin_video_src: video source model driving pixel clock and syncs
`timescale 1ns/1ps
`default_nettype none
module vidwin_video_src (
   // link pins
   output logic pclk_out,
   output logic hsync_out,
   output logic vsync_out
);
   logic [25:0] exp_q [$];
   logic [15:0] line_c;
   logic [9:0] pix_c;
   logic hs_p;
   logic vs_p;
   logic sel_c;
   initial begin
      pclk_out = 1'h0;
      hsync_out = 1'h0;
      vsync_out = 1'h0;
      line_c = 16'h0000;
      pix_c = 10'h000;
      hs_p = 1'h0;
      vs_p = 1'h0;
      sel_c = 1'h0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // mirror of the counters, queued per rise so latency never matters
   always @(posedge pclk_out) begin
      if (sel_c ? (vs_p && !vsync_out) : (vsync_out && !vs_p)) line_c = 16'h0000;
      else if (hsync_out && !hs_p && line_c != 16'hFFFF) line_c = line_c + 16'h0001;
      if (hsync_out && !hs_p) pix_c = 10'h000;
      else if (pix_c != 10'h3FF) pix_c = pix_c + 10'h001;
      hs_p = hsync_out;
      vs_p = vsync_out;
      exp_q.push_back({line_c, pix_c});
   end
   // clock stands still outside frames; syncs change only at the fall
   task run_frame(input int nl, input int np, input logic sel);
      sel_c = sel;
      #37;
      for (int l = 0; l < nl; l++) begin
         for (int p = 0; p < np; p++) begin
            hsync_out = (p < 2);
            vsync_out = (l == 0 && p >= 4) || l == 1 || (l == 2 && p < 4);
            #400 pclk_out = 1'h1;
            #400 pclk_out = 1'h0;
         end
      end
      hsync_out = 1'h0;
      vsync_out = 1'h0;
   endtask : run_frame
endmodule : vidwin_video_src
`default_nettype wire

// ===== test/test_vidwin_top.sv
// test_vidwin_top: self-checking bench for the window timing block
`timescale 1ns/1ps
`default_nettype none
module test_vidwin_top;
   import vidwin_pkg::*;
   logic clk, rst, wr, rd, pclk, hs, vs, act, sub, stb, pol, sel, mst;
   logic pend = 1'h0;
   logic [7:0] addr, wdata, rdata, d;
   logic [15:0] lim [8];
   logic [25:0] cur;
   int n_errors, n_tests;
   ////////////////////////////////////////////////////////////////////////////
   vidwin_top dut (.CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(1'h1),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
      .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .VIDEO_PIXEL_CLOCK_IN(pclk),
      .HSYNC_IN(hs), .VSYNC_IN(vs), .ACTIVE_PIXEL_OUT(act),
      .SUBIMAGE_INDICATOR_OUT(sub), .PIXEL_STROBE_OUT(stb));
   vidwin_video_src src (.pclk_out(pclk), .hsync_out(hs), .vsync_out(vs));
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task results;
      $display("Tests: %0d errors: %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   task wr_reg(input logic [7:0] a, input logic [7:0] v, input bit chk);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      if (chk) begin
         rd <= 1'h1;
         @(posedge clk);
         rd <= 1'h0;
         @(negedge clk);
         check({8'h00, rdata}, {8'h00, v});
      end
   endtask : wr_reg
   task rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      v = rdata;
   endtask : rd_reg
   // inside test: start < count <= end on both axes
   function logic inwin(input logic [25:0] c, input int b);
      return c[25:10] > lim[b] && c[25:10] <= lim[b+1] &&
         c[9:0] > lim[b+2][9:0] && c[9:0] <= lim[b+3][9:0];
   endfunction : inwin
   ////////////////////////////////////////////////////////////////////////////
   // each strobe takes one queued position; outputs are judged a cycle later
   always @(negedge clk) begin
      if (pend) begin
         check({15'h0, act}, {15'h0, inwin(cur, 0)});
         check({15'h0, sub}, {15'h0, inwin(cur, 4) ^ pol});
      end
      pend = 1'h0;
      if (stb === 1'h1 && src.exp_q.size() == 0) check(16'h0001, 16'h0000);
      else if (stb === 1'h1) begin
         cur = src.exp_q.pop_front();
         pend = 1'h1;
      end
   end
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      results();
   end
   initial begin
      rst = 1'h1;
      wr = 1'h0;
      rd = 1'h0;
      addr = 8'h00;
      wdata = 8'h00;
      pol = 1'h0;
      n_errors = 0;
      n_tests = 0;
      void'($urandom(72));
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      for (int i = 0; i < WIN_REG_COUNT; i++) begin
         rd_reg(ACTIVE_VERT_START_HIGH_OFS + 8'(i), d);
         check({8'h00, d}, {8'h00, WINDOW_RESET});
      end
      wr_reg(8'h60, 8'hA5, 1'b0);
      rd_reg(8'h60, d);
      check({8'h00, d}, {8'h00, UNMAPPED_READ});
      for (int k = 0; k < 6; k++) begin
         sel = k[0];
         pol = k[1];
         mst = 1'($urandom);
         // spans stay far below the host limits
         // header counts live outside this block, derived from lim
         for (int i = 0; i < 8; i += 2) begin
            lim[i] = 16'(i[1] ? $urandom_range(17) : $urandom_range(12));
            lim[i+1] = lim[i] + 16'($urandom_range(6));
         end
         if (k == 0) lim[1] = 16'h0100;
         if (k == 1) lim[5] = lim[4];
         wr_reg(VIDEO_CONTROL_OFS, {5'h00, sel, 1'h0, mst}, 1'b1);
         wr_reg(VIDEO_POLARITY_OFS, {3'h0, pol, 4'h3}, 1'b1);
         // junk in the upper bits of horizontal high bytes must be ignored
         for (int i = 0; i < 8; i++) begin
            wr_reg(ACTIVE_VERT_START_HIGH_OFS + 8'(2 * i), i[1] ?
               {6'($urandom), lim[i][9:8]} : lim[i][15:8], !i[1]);
            wr_reg(ACTIVE_VERT_START_HIGH_OFS + 8'(2 * i + 1), lim[i][7:0], 1'b1);
         end
         src.run_frame(14, 20, sel);
         repeat (20) @(posedge clk);
         check(16'(src.exp_q.size()), 16'h0000);
      end
      results();
   end
endmodule : test_vidwin_top
`default_nettype wire
